/* File: include/dli_consts.svh */
/*
 * Offsets, field positions, reset values and encodings of the die link initiator.
 * Assumes inclusion by bare name from files that need the numbers.
 */
`ifndef DLI_CONSTS_SVH
`define DLI_CONSTS_SVH

// Bus address width, byte address = 4 * register index
`define DLI_AW 12
// Register indices inside the control block
`define DLI_IDX_CTRL 4'h0
`define DLI_IDX_TOCTL 4'h1
`define DLI_IDX_ERR 4'h2
`define DLI_IDX_BSY 4'h3
`define DLI_IDX_ATTR 4'h4
`define DLI_IDX_ADDR 4'h5
`define DLI_IDX_DHI 4'h6
`define DLI_IDX_DLO 4'h7
`define DLI_IDX_ISTAT 4'h8
`define DLI_IDX_IMASK 4'h9
// Window selects on address bits 11:8
`define DLI_WIN_BLK 4'h1
`define DLI_WIN_NONBLOCKING_FLAG 4'h2
// Field positions
`define DLI_CTL_EN 7
`define DLI_CTL_CW 6
`define DLI_CTL_SWAI 5
`define DLI_TOC_IE 7
`define DLI_ERR_SUM 7
`define DLI_ERR_ACK 6
`define DLI_ERR_CNL 5
`define DLI_ERR_TIME 4
`define DLI_IRQ_ERR 0
`define DLI_IRQ_DONE 1
`define DLI_IRQ_TGT 2
// Reset values
`define DLI_CTRL_RST 8'h00
`define DLI_TOCTL_RST 8'h00
`define DLI_IRQ_RST 3'h0
// Command byte: start marker, direction, size, posted
`define DLI_CMD_START 8'h80
`define DLI_CMD_RNW 6
`define DLI_CMD_SZ8 5
`define DLI_CMD_NONBLOCKING_FLAG 4
// Active line masks
`define DLI_MASK4 8'h0F
`define DLI_MASK8 8'hFF

`endif

/* File: include/dli_pkg.sv */
/*
 * Types of the die link initiator: control layout, pin bundle, engine states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dli_pkg;

  // Link control register layout
  typedef struct packed {
    logic link_enable;
    logic line_width_select;
    logic stop_wait_halt;
    logic [2:0] rsv;
    logic [1:0] iface_clock_divider;
  } dli_ctrl_s;

  // Link pins as driven by the initiator
  typedef struct packed {
    logic link_clock_out;
    logic clock_oe;
    logic [7:0] link_data_lines;
    logic [7:0] data_oe;
  } dli_pins_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TX,
    ST_RX,
    ST_ACK
  } dli_state_e;

endpackage : dli_pkg

/* File: hdl/dli_clkdiv.sv */
/*
 * Interface clock divider of the die link initiator: divide by 2..4, short high phase.
 * Assumes the ratio is stable while running and a synchronous halt request.
 */
`timescale 1ns/10ps
`include "dli_consts.svh"

module dli_clkdiv
  import dli_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run_en,
  input wire logic halt_req,
  input wire logic [1:0] ratio,
  output logic link_clk_q,
  output logic tick_q
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [1:0] half;

  // Next count wraps at ratio; high phase is floor(N/2) cycles
  assign cnt_d = (cnt_q == ratio) ? 2'h0 : cnt_q + 2'h1;
  assign half = 2'((3'(ratio) + 3'h1) >> 1);

  // Counter and clock level; frozen low once halted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 2'h0;
      link_clk_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else if (!run_en)
    begin
      cnt_q <= 2'h0;
      link_clk_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else if (halt_req && !link_clk_q)
    begin
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= (cnt_d == 2'h0);
      // Ratio zero toggles every bus clock, dividing by two; a flop cannot copy pclk itself
      if (ratio == 2'h0)
        link_clk_q <= ~link_clk_q;
      else
        link_clk_q <= (cnt_d < half);
    end
  end

endmodule : dli_clkdiv

/* File: hdl/dli_top.sv */
/*
 * Die link initiator: APB register block, two 256-byte transaction windows,
 * a serial link engine on 4 or 8 lines and the divided interface clock.
 * Assumes synchronous pins, a target that answers with an acknowledge beat
 * and an APB master that holds its request until pready.
 */
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "dli_consts.svh"

// Overview of operation
// - Decode ten control registers plus blocking and posted-write windows.
// - Each window spans 256 bytes; low address byte selects target location.
// - Link disabled: no pin enables, pins left to general-purpose use.
// - Link enabled and idle: active data lines driven low as idle command.
// - Enabled link drives interface clock from divided bus clock.
// - Link enable is write-once in normal mode, free in special mode.
// - Width bit zero: four lines 3:0 used, 7:4 untouched; write-once.
// - Width bit one: all eight data lines carry each beat.
// - Divider encodings 00,01,10,11 divide bus clock by 2,2,3,4.
// - Divider field write-once in normal mode, free in special mode.
// - Interface clock high phase never exceeds half the period.
// - Window write sends write command, 8-bit address, then data.
// - Window read sends read command and address; target returns data.
// - Stop with stop-wait bit set holds interface clock low.
// - Stop with stop-wait bit set drives clock and data low after current high phase.
module dli_top
  import dli_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DLI_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode,
  input wire logic stop_req,
  input wire logic [7:0] link_data_in,
  input wire logic target_irq_in,
  output dli_pins_s link_pins,
  output logic irq
);

  dli_ctrl_s ctrl_q;
  logic lock_q;
  logic irq_en_q;
  logic [3:0] timeout_q;
  logic [7:0] err_q;
  logic [2:0] istat_q;
  logic [2:0] istat_d;
  logic [2:0] imask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic pend_q;
  logic irq_q;
  dli_state_e st_q;
  logic [3:0] beats_q;
  logic [3:0] wait_q;
  logic [31:0] tx_q;
  logic [15:0] rx_q;
  logic rnw_q;
  logic sz8_q;
  logic nonblocking_flag_q;
  logic [7:0] loc_q;
  logic [15:0] data_q;
  dli_pins_s pins_q;
  logic link_clk;
  logic tick;

  logic [3:0] reg_idx;
  logic reg_hit;
  logic blk_hit;
  logic nonblocking_flag_hit;
  logic win_hit;
  logic setup;
  logic reg_wr;
  logic win_acc;
  logic go;
  logic refuse;
  logic req_rnw;
  logic req_sz8;
  logic req_nb;
  logic [7:0] mask;
  logic [7:0] act;
  logic fin;
  logic fin_ack_err;
  logic fin_time_err;
  logic halted;
  logic [31:0] rd_mux;
  logic [3:0] rx_beats;

  assign reg_idx = paddr[5:2];
  assign reg_hit = (paddr[`DLI_AW-1:6] == 6'h00) && (reg_idx <= `DLI_IDX_IMASK);
  assign blk_hit = (paddr[`DLI_AW-1:8] == `DLI_WIN_BLK);
  assign nonblocking_flag_hit = (paddr[`DLI_AW-1:8] == `DLI_WIN_NONBLOCKING_FLAG);
  assign win_hit = blk_hit || nonblocking_flag_hit;
  assign setup = psel && !penable;
  assign reg_wr = psel && penable && pready_q && pwrite && reg_hit;
  assign win_acc = psel && penable && win_hit && !pend_q && !pready_q;

  // Reads of the posted window fall back to blocking reads
  assign req_rnw = !pwrite;
  assign req_nb = nonblocking_flag_hit && pwrite;
  assign req_sz8 = pwrite ? (pstrb[1:0] != 2'b11 || paddr[0]) : paddr[0];
  // Disabled link or pending error refuses at once; busy engine makes it wait
  assign refuse = win_acc && (!ctrl_q.link_enable || err_q[`DLI_ERR_SUM]);
  assign go = win_acc && !refuse && (st_q == ST_IDLE);

  assign mask = ctrl_q.line_width_select ? `DLI_MASK8 : `DLI_MASK4;
  assign act = link_data_in & mask;
  assign rx_beats = ctrl_q.line_width_select ? (sz8_q ? 4'd1 : 4'd2) : (sz8_q ? 4'd2 : 4'd4);

  // Acknowledge beat outcome: all high ok, all low wait, anything else fault
  assign fin = tick && (st_q == ST_ACK) && ((act != 8'h00) || (wait_q == timeout_q));
  assign fin_ack_err = fin && (act != 8'h00) && (act != mask);
  assign fin_time_err = fin && (act == 8'h00);

  assign halted = stop_req && ctrl_q.stop_wait_halt && !link_clk;

  dli_clkdiv u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run_en(ctrl_q.link_enable),
    .halt_req(stop_req && ctrl_q.stop_wait_halt),
    .ratio(ctrl_q.iface_clock_divider),
    .link_clk_q(link_clk),
    .tick_q(tick)
  );

  // Control registers with write-once lock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `DLI_CTRL_RST;
      lock_q <= 1'b0;
      irq_en_q <= 1'b0;
      timeout_q <= 4'h0;
      imask_q <= `DLI_IRQ_RST;
    end
    else if (reg_wr)
    begin
      if (reg_idx == `DLI_IDX_CTRL)
      begin
        ctrl_q.stop_wait_halt <= pwdata[`DLI_CTL_SWAI];
        if (!lock_q || special_mode)
        begin
          ctrl_q.link_enable <= pwdata[`DLI_CTL_EN];
          ctrl_q.line_width_select <= pwdata[`DLI_CTL_CW];
          ctrl_q.iface_clock_divider <= pwdata[1:0];
          lock_q <= lock_q || pwdata[`DLI_CTL_EN];
        end
      end
      if (reg_idx == `DLI_IDX_TOCTL)
      begin
        irq_en_q <= pwdata[`DLI_TOC_IE];
        if (!lock_q || special_mode)
          timeout_q <= pwdata[3:0];
      end
      if (reg_idx == `DLI_IDX_IMASK)
        imask_q <= pwdata[2:0];
    end
  end

  // Error flags; summary write-one clears all, new errors win
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_q <= 8'h00;
    else
    begin
      if (reg_wr && reg_idx == `DLI_IDX_ERR && pwdata[`DLI_ERR_SUM])
        err_q <= {1'b0, 7'h00};
      if (fin_ack_err)
      begin
        err_q[`DLI_ERR_ACK] <= 1'b1;
        err_q[`DLI_ERR_SUM] <= 1'b1;
      end
      if (fin_time_err)
      begin
        err_q[`DLI_ERR_TIME] <= 1'b1;
        err_q[`DLI_ERR_SUM] <= 1'b1;
      end
      if (refuse && ctrl_q.link_enable)
        err_q[`DLI_ERR_CNL] <= 1'b1;
    end
  end

  // Interrupt status, write-one-to-clear, events win over the clear
  always_comb
  begin
    istat_d = istat_q;
    if (reg_wr && reg_idx == `DLI_IDX_ISTAT)
      istat_d = istat_q & ~pwdata[2:0];
    if (fin_ack_err || fin_time_err)
      istat_d[`DLI_IRQ_ERR] = 1'b1;
    if (fin)
      istat_d[`DLI_IRQ_DONE] = 1'b1;
    if (target_irq_in && irq_en_q)
      istat_d[`DLI_IRQ_TGT] = 1'b1;
  end

  // Interrupt flops; output follows the masked next state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      istat_q <= `DLI_IRQ_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      istat_q <= istat_d;
      irq_q <= |(istat_d & imask_q);
    end
  end

  // Register read mux
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (reg_idx)
      `DLI_IDX_CTRL: rd_mux[7:0] = {ctrl_q.link_enable, ctrl_q.line_width_select,
                                    ctrl_q.stop_wait_halt, 3'b000, ctrl_q.iface_clock_divider};
      `DLI_IDX_TOCTL: rd_mux[7:0] = {irq_en_q, 3'b000, timeout_q};
      `DLI_IDX_ERR: rd_mux[7:0] = err_q;
      `DLI_IDX_BSY: rd_mux[7:0] = {target_irq_in && irq_en_q, st_q != ST_IDLE, 6'h00};
      `DLI_IDX_ATTR: rd_mux[7:0] = {rnw_q, sz8_q, 1'b0, nonblocking_flag_q, 4'h0};
      `DLI_IDX_ADDR: rd_mux[7:0] = loc_q;
      `DLI_IDX_DHI: rd_mux[7:0] = data_q[15:8];
      `DLI_IDX_DLO: rd_mux[7:0] = data_q[7:0];
      `DLI_IDX_ISTAT: rd_mux[2:0] = istat_q;
      `DLI_IDX_IMASK: rd_mux[2:0] = imask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // APB answer: registers in one access cycle, windows when the engine allows
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      if (setup && reg_hit)
      begin
        pready_q <= 1'b1;
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end
      else if (setup && !win_hit)
      begin
        pready_q <= 1'b1;
        pslverr_q <= 1'b1;
        prdata_q <= 32'h0000_0000;
      end
      else if (refuse)
      begin
        pready_q <= 1'b1;
        pslverr_q <= 1'b1;
        prdata_q <= 32'h0000_0000;
      end
      else if (go && req_nb)
        pready_q <= 1'b1;
      else if (go)
        pend_q <= 1'b1;
      else if (fin && pend_q)
      begin
        pend_q <= 1'b0;
        pready_q <= 1'b1;
        pslverr_q <= fin_ack_err || fin_time_err;
        prdata_q <= rnw_q ? {16'h0000, sz8_q ? {8'h00, rx_q[7:0]} : rx_q} : 32'h0000_0000;
      end
    end
  end

  // Link engine: transmit beats, receive beats, acknowledge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_IDLE;
      beats_q <= 4'h0;
      wait_q <= 4'h0;
      tx_q <= 32'h0000_0000;
      rx_q <= 16'h0000;
    end
    else if (!ctrl_q.link_enable)
      st_q <= ST_IDLE;
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (go)
          begin
            // Read sends command and address only
            tx_q <= {`DLI_CMD_START | {1'b0, req_rnw, req_sz8, req_nb, 4'h0}, paddr[7:0],
                     req_sz8 ? {pwdata[7:0], 8'h00} : pwdata[15:0]};
            if (ctrl_q.line_width_select)
              beats_q <= req_rnw ? 4'd2 : (req_sz8 ? 4'd3 : 4'd4);
            else
              beats_q <= req_rnw ? 4'd4 : (req_sz8 ? 4'd6 : 4'd8);
            wait_q <= 4'h0;
            st_q <= ST_TX;
          end
        end
        ST_TX:
        begin
          if (tick && beats_q != 4'h0)
          begin
            tx_q <= ctrl_q.line_width_select ? {tx_q[23:0], 8'h00} : {tx_q[27:0], 4'h0};
            beats_q <= beats_q - 4'h1;
          end
          else if (tick)
          begin
            beats_q <= rx_beats;
            st_q <= rnw_q ? ST_RX : ST_ACK;
          end
        end
        ST_RX:
        begin
          if (tick)
          begin
            rx_q <= ctrl_q.line_width_select ? {rx_q[7:0], link_data_in} :
                    {rx_q[11:0], link_data_in[3:0]};
            beats_q <= beats_q - 4'h1;
            if (beats_q == 4'h1)
              st_q <= ST_ACK;
          end
        end
        ST_ACK:
        begin
          if (fin)
            st_q <= ST_IDLE;
          else if (tick)
            wait_q <= wait_q + 4'h1;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rnw_q <= 1'b0;
      sz8_q <= 1'b0;
      nonblocking_flag_q <= 1'b0;
      loc_q <= 8'h00;
      data_q <= 16'h0000;
    end
    else if (go)
    begin
      rnw_q <= req_rnw;
      sz8_q <= req_sz8;
      nonblocking_flag_q <= req_nb;
      loc_q <= paddr[7:0];
      data_q <= req_sz8 ? {8'h00, pwdata[7:0]} : pwdata[15:0];
    end
    else if (fin && rnw_q)
      data_q <= sz8_q ? {8'h00, rx_q[7:0]} : rx_q;
  end

  // Pin drive; lines change on beats so the target sees a full period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pins_q <= '0;
    else
    begin
      pins_q.link_clock_out <= link_clk && ctrl_q.link_enable;
      pins_q.clock_oe <= ctrl_q.link_enable;
      if (!ctrl_q.link_enable)
      begin
        pins_q.link_data_lines <= 8'h00;
        pins_q.data_oe <= 8'h00;
      end
      else if (halted)
      begin
        pins_q.link_data_lines <= 8'h00;
        pins_q.data_oe <= mask;
      end
      else if (st_q == ST_IDLE)
      begin
        pins_q.link_data_lines <= 8'h00;
        pins_q.data_oe <= mask;
      end
      else if (st_q == ST_TX && tick && beats_q != 4'h0)
      begin
        pins_q.link_data_lines <= ctrl_q.line_width_select ? tx_q[31:24] :
                                  {4'h0, tx_q[31:28]};
        pins_q.data_oe <= mask;
      end
      // Turnaround: target drives data and acknowledge
      else if (st_q == ST_TX && tick)
        pins_q.data_oe <= 8'h00;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign link_pins = pins_q;
  assign irq = irq_q;

endmodule : dli_top

/* File: verif/dli_assertions.sv */
/*
 * Port checker for dli_top: bus answers, pin enables, clock phases.
 * Assumes a bind from the bench top file and one clock domain.
 */
`timescale 1ns/10ps
`include "dli_consts.svh"

module dli_chk
  import dli_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DLI_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stop_req,
  input wire dli_pins_s link_pins,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic win;
  logic [2:0] hi_q;
  logic [2:0] lo_q;
  // Completed access and window decode
  assign acc = psel && penable && pready;
  assign win = paddr[11:8] == 4'h1 || paddr[11:8] == 4'h2;
  // Phase lengths; stop and disable legitimately stretch the low phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hi_q <= 3'h0;
      lo_q <= 3'h0;
    end
    else
    begin
      hi_q <= link_pins.link_clock_out ? hi_q + 3'h1 : 3'h0;
      lo_q <= (link_pins.link_clock_out || !link_pins.clock_oe || stop_req) ? 3'h0 : lo_q + 3'h1;
    end
  end
  property p_unmapped;
    acc && (paddr[11:8] > 4'h2 || (paddr[11:8] == 4'h0 && paddr[7:0] > 8'h27)) |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  property p_zero_wait;
    psel && !penable && paddr[11:8] == 4'h0 |=> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("register access waited");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_rsv;
    acc && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h00_0000 && prdata[4:2] == 3'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved control bits nonzero");
  property p_oe_mask;
    link_pins.data_oe inside {8'h00, 8'h0F, 8'hFF};
  endproperty
  a_oe_mask: assert property (p_oe_mask) else $error("odd data line enables");
  property p_clk_oe;
    !link_pins.clock_oe |-> !link_pins.link_clock_out && link_pins.data_oe == 8'h00;
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("pins used while disabled");
  property p_hi;
    hi_q <= 3'h2;
  endproperty
  a_hi: assert property (p_hi) else $error("clock high phase too long");
  property p_lo;
    lo_q <= 3'h3;
  endproperty
  a_lo: assert property (p_lo) else $error("clock stopped while enabled");
  property p_refuse;
    acc && win && !link_pins.clock_oe |-> pslverr;
  endproperty
  a_refuse: assert property (p_refuse) else $error("window used while disabled");
  property p_irq;
    acc && pwrite && paddr == 12'h024 && pwdata[2:0] == 3'h0 |=> ##[0:1] !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt stays up when masked");
endmodule : dli_chk

/* File: verif/dli_target.sv */
/*
 * Behavioural target die: answers released lines, resolves the wire level.
 * Assumes the bench raises stall to make the target hold the lines low.
 */
`timescale 1ns/10ps

module dli_target
  import dli_pkg::*;
(
  input wire dli_pins_s link_pins,
  input wire logic stall,
  output logic [7:0] link_data_in
);
  logic [7:0] tgt;
  // answer data and acknowledge as all ones once released
  assign tgt = (link_pins.clock_oe && link_pins.data_oe == 8'h00 && !stall) ? 8'hFF : 8'h00;
  // Initiator where it drives, else target; pull-downs hold idle lines low
  assign link_data_in = (link_pins.data_oe & link_pins.link_data_lines) | (~link_pins.data_oe & tgt);
endmodule : dli_target

/* File: verif/tb_top.sv */
/*
 * Directed bench for dli_top over APB with a target model on the link.
 * Assumes dli_chk and dli_target are compiled before this file.
 */
`timescale 1ns/10ps
`include "dli_consts.svh"

module tb_top
  import dli_pkg::*;
;
  localparam logic [31:0] k_one = 32'h0000_0001;
  localparam logic [31:0] k_zero = 32'h0000_0000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`DLI_AW-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic special_mode = 1'b0;
  logic stop_req = 1'b0;
  logic target_irq_in = 1'b0;
  logic stall = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [7:0] link_data_in;
  dli_pins_s link_pins;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int n_compared = 0;
  int per;
  int hi;

  // 200 MHz bus clock
  always #2.5 pclk = ~pclk;

  dli_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .special_mode, .stop_req, .link_data_in, .target_irq_in, .link_pins, .irq);
  dli_target u_tgt (.link_pins, .stall, .link_data_in);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask : chk

  // One APB transfer; a clock edge always separates release and next setup
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
  begin
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'h3;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 200)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 200)
      chk(k_zero, k_one);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask : xfer

  task automatic rc(input logic [11:0] a, input logic [7:0] exp);
  begin
    xfer(1'b0, a, k_zero);
    chk(rd, {24'h00_0000, exp});
  end
  endtask : rc

  // Interface clock period and high phase in bus clocks, settled period
  task automatic measure(input int d);
  begin
    repeat (2) @(posedge link_pins.link_clock_out);
    per = 0;
    hi = 0;
    fork
      @(posedge link_pins.link_clock_out);
      forever
      begin
        @(posedge pclk);
        per++;
        hi += 32'(link_pins.link_clock_out);
      end
    join_any
    disable fork;
    chk(per, (d == 0) ? 2 : d + 1);
    chk(hi, ((d == 0) ? 2 : d + 1) / 2);
  end
  endtask : measure

  task automatic conclude();
  begin
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask : conclude

  // Hang guard well beyond the directed sequence
  initial
  begin
    #200000;
    errors++;
    conclude();
  end

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rc(12'h000, 8'h00);
    chk(32'(link_pins), k_zero);
    rc(12'h030, 8'h00);
    chk(32'(err), k_one);
    xfer(1'b1, 12'h105, 32'h0000_0011);
    chk(32'(err), k_one);
    $display("test reset done");
    xfer(1'b1, 12'h000, 32'h0000_0081);
    xfer(1'b1, 12'h000, 32'h0000_0043);
    rc(12'h000, 8'h81);
    chk(32'(link_pins.data_oe), 32'h0000_000F);
    chk(32'(link_pins.link_data_lines), k_zero);
    measure(1);
    $display("test enable done");
    xfer(1'b1, 12'h205, 32'h0000_00A5);
    rc(12'h010, 8'h50);
    rc(12'h014, 8'h05);
    rc(12'h01C, 8'hA5);
    xfer(1'b1, 12'h014, 32'h0000_00FF);
    rc(12'h014, 8'h05);
    xfer(1'b0, 12'h110, k_zero);
    chk(rd, 32'h0000_FFFF);
    rc(12'h010, 8'h80);
    $display("test transfer done");
    stall <= 1'b1;
    xfer(1'b0, 12'h111, k_zero);
    chk(32'(err), k_one);
    rc(12'h008, 8'h90);
    chk(32'(irq), k_zero);
    xfer(1'b1, 12'h024, k_one);
    repeat (2) @(posedge pclk);
    chk(32'(irq), k_one);
    xfer(1'b1, 12'h020, k_one);
    repeat (2) @(posedge pclk);
    chk(32'(irq), k_zero);
    xfer(1'b1, 12'h024, k_zero);
    xfer(1'b1, 12'h101, k_one);
    rc(12'h008, 8'hB0);
    xfer(1'b1, 12'h008, 32'h0000_0080);
    rc(12'h008, 8'h00);
    stall <= 1'b0;
    $display("test error done");
    special_mode <= 1'b1;
    for (int d = 0; d < 4; d++)
    begin
      xfer(1'b1, 12'h000, 32'h0000_0080 | 32'(d));
      measure(d);
    end
    xfer(1'b1, 12'h000, 32'h0000_00C3);
    rc(12'h000, 8'hC3);
    chk(32'(link_pins.data_oe), 32'h0000_00FF);
    xfer(1'b1, 12'h004, 32'h0000_0083);
    fork
      xfer(1'b1, 12'h1F0, 32'h0000_1234);
      begin
        stall <= 1'b1;
        repeat (30) @(posedge pclk); // One ack wait, under the timeout
        stall <= 1'b0;
      end
    join
    chk(32'(err), k_zero);
    rc(12'h008, 8'h00);
    xfer(1'b0, 12'h1F1, k_zero);
    chk(rd, 32'h0000_00FF);
    target_irq_in <= 1'b1;
    rc(12'h00C, 8'h80);
    $display("test special done");
    xfer(1'b1, 12'h000, 32'h0000_00A1);
    stop_req <= 1'b1;
    repeat (6) @(posedge pclk);
    repeat (8)
    begin
      @(posedge pclk);
      chk(32'(link_pins.link_clock_out), k_zero);
      chk(32'(link_pins.link_data_lines), k_zero);
    end
    stop_req <= 1'b0;
    measure(1);
    $display("test stop done");
    conclude();
  end
endmodule : tb_top

bind dli_top dli_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .stop_req, .link_pins, .irq);
